// ---- hw/eee_lpi_params.svh ----
// Offsets, field positions, reset values for the EEE LPI register bank
`ifndef EEE_LPI_PARAMS_SVH
`define EEE_LPI_PARAMS_SVH

// Register indices; byte address is four times the index
`define EEE_IDX_CFG2      16'h04D0
`define EEE_IDX_CFG3      16'h04D1
`define EEE_IDX_PCS_CTRL  16'h3000
`define EEE_IDX_PCS_STAT  16'h3001
`define EEE_IDX_CAP       16'h3014
`define EEE_IDX_WAKE_CNT  16'h3016
`define EEE_IDX_ADV       16'h703C

// Configuration register two
`define EEE_CFG2_LPI_TXER_BIT  14
`define EEE_CFG2_SEL_LSB       5
`define EEE_CFG2_RSVD_HI_RST   7'h06
`define EEE_CFG2_RSVD_LO_RST   5'h02
`define EEE_SEL_IRQ_PD         2'h1
`define EEE_SEL_COL_GPIO       2'h2

// Configuration register three
`define EEE_CFG3_RSVD_RST      12'h018
`define EEE_CFG3_BYPASS_BIT    3
`define EEE_CFG3_NP_DIS_BIT    2
`define EEE_CFG3_RX_SD_BIT     1
`define EEE_CFG3_CAP_EN_BIT    0
`define EEE_CFG3_BYPASS_RST    1'b1
`define EEE_CFG3_NP_DIS_RST    1'b0
`define EEE_CFG3_RX_SD_RST     1'b1

// PCS control, status, capability, advertisement
`define EEE_CTRL_RESET_BIT     15
`define EEE_CTRL_RXCLK_BIT     10
`define EEE_STAT_TX_SEEN_BIT   11
`define EEE_STAT_RX_SEEN_BIT   10
`define EEE_STAT_TX_NOW_BIT    9
`define EEE_STAT_RX_NOW_BIT    8
`define EEE_STAT_TXCLK_BIT     6
`define EEE_CAP_1000T_BIT      2
`define EEE_CAP_100TX_BIT      1
`define EEE_ADV_100TX_BIT      1
`define EEE_ADV_100TX_RST      1'b1
`define EEE_RXCLK_RST          1'b0

`endif

// ---- hw/eee_lpi_pkg.sv ----
// Types shared by the EEE LPI register bank
package eee_lpi_pkg;

  typedef enum logic [2:0] {
    EEE_SEL_NONE  = 3'b000,
    EEE_SEL_CFG2  = 3'b001,
    EEE_SEL_CFG3  = 3'b010,
    EEE_SEL_CTRL  = 3'b011,
    EEE_SEL_STAT  = 3'b100,
    EEE_SEL_CAP   = 3'b101,
    EEE_SEL_WAKE  = 3'b110,
    EEE_SEL_ADV   = 3'b111
  } eee_reg_sel_t;

endpackage

// ---- hw/eee_wake_cnt.sv ----
// Saturating wake error counter with clear that loses no event
module eee_wake_cnt #(
  parameter int CNT_W = 16
) (
  input  wire logic             sys_clk,
  input  wire logic             rst,
  input  wire logic             inc,
  input  wire logic             clr,
  output logic      [CNT_W-1:0] count_q
);

  typedef struct packed {
    logic [CNT_W-1:0] count;
  } eee_cnt_state_t;

  eee_cnt_state_t st_q;
  eee_cnt_state_t st_d;

  generate
    if (CNT_W < 1) begin : g_bad_width
      $error("eee_wake_cnt: CNT_W must be at least 1");
    end
  endgenerate

  always_comb begin
    st_d = st_q;
    if (clr) begin
      // A fault in the clearing cycle starts the new count at one
      st_d.count = {{(CNT_W-1){1'b0}}, inc};
    end else if (inc && (st_q.count != {CNT_W{1'b1}})) begin
      st_d.count = st_q.count + {{(CNT_W-1){1'b0}}, 1'b1};
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign count_q = st_q.count;

endmodule // eee_wake_cnt

// ---- hw/eee_lpi_regs.sv ----
// EEE low power idle configuration and status register bank, APB slave
//
// Contract
// - Bit 14 set makes TX_ER carry the MAC's LPI request; clear ignores it.
// - Pin select 01 irq/powerdown pin, 10 collision/GPIO pin, else none.
// - Bypass set: advertised EEE follows enable bit; clear: MMD3/MMD7.
// - Next page disable set stops accepting EEE next pages.
// - Shutdown bit set powers down analog receive path in quiet state.
// - Capability enable set: negotiate EEE per advertisement and partner.
// - Capability enable clear: capability and advertisement ignored.
// - Writing 1 to bit 15 soft-resets PCS registers, then bit self-clears.
// - Soft reset leaves vendor configuration registers unchanged.
// - Receive clock stoppable bit permits stopping receive clock in LPI.
// - Status bits 11 and 10 report TX and RX PCS received LPI.
// - Status bits 9 and 8 show TX and RX PCS currently in LPI.
// - Status bit 6 shows TX clock stoppable; MAC stops clock only then.
// - Capability bits 1 and 2 show 100TX and 1000T EEE; zero default.
// - Sixteen-bit counter increments on each failed wake sequence.
// - Wake counter clears on read and saturates at all ones.
// - Soft reset also clears the wake error counter.
// - Advertisement bit 1 advertises 100TX EEE, read-write, default one.
//
// Decided for this implementation: the APB slave port.
`include "eee_lpi_params.svh"

module eee_lpi_regs #(
  parameter int       ADDR_W     = 16,
  parameter int       CNT_W      = 16,
  parameter bit       CAP_100TX  = 1'b0,
  parameter bit       CAP_1000T  = 1'b0
) (
  input  wire logic              sys_clk,
  input  wire logic              rst,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  input  wire logic [3:0]        pstrb,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              strap_cap_en,
  input  wire logic              tx_er,
  input  wire logic              tx_lpi_active,
  input  wire logic              rx_lpi_active,
  input  wire logic              lpi_quiet,
  input  wire logic              tx_clk_stop_ok,
  input  wire logic              wake_err,
  output logic                   lpi_req,
  output logic                   txer_on_irq_pin,
  output logic                   txer_on_col_pin,
  output logic                   eee_adv_100tx,
  output logic                   eee_neg_en,
  output logic                   next_page_accept,
  output logic                   rx_path_pd,
  output logic                   rx_clk_stop_ok,
  output logic                   pcs_soft_reset
);

  typedef struct packed {
    logic        lpi_txer_en;
    logic [1:0]  pin_sel;
    logic [11:0] cfg3_rsvd;
    logic        bypass;
    logic        np_dis;
    logic        rx_sd;
    logic        cap_en;
    logic        strap_done;
    logic        rx_clk_stop;
    logic        pcs_rst;
    logic        adv100;
    logic        tx_seen;
    logic        rx_seen;
    logic [15:0] rdata;
    logic        err;
  } eee_regs_state_t;

  eee_regs_state_t       st_q;
  eee_regs_state_t       st_d;
  eee_lpi_pkg::eee_reg_sel_t sel;
  logic                  setup;
  logic                  wr_acc;
  logic                  cnt_clr;
  logic [CNT_W-1:0]      wake_cnt;
  logic [15:0]           wdata;

  generate
    if (ADDR_W < 16) begin : g_bad_addr
      $error("eee_lpi_regs: ADDR_W must be at least 16");
    end
    if (CNT_W != 16) begin : g_bad_cnt
      $error("eee_lpi_regs: wake counter must be 16 bits");
    end
  endgenerate

  // Byte address of a register index
  function automatic logic [ADDR_W-1:0] byte_addr(input logic [15:0] idx);
    byte_addr = ADDR_W'({idx, 2'b00});
  endfunction

  function automatic eee_lpi_pkg::eee_reg_sel_t decode(
    input logic [ADDR_W-1:0] a
  );
    if (a == byte_addr(`EEE_IDX_CFG2)) begin
      decode = eee_lpi_pkg::EEE_SEL_CFG2;
    end else if (a == byte_addr(`EEE_IDX_CFG3)) begin
      decode = eee_lpi_pkg::EEE_SEL_CFG3;
    end else if (a == byte_addr(`EEE_IDX_PCS_CTRL)) begin
      decode = eee_lpi_pkg::EEE_SEL_CTRL;
    end else if (a == byte_addr(`EEE_IDX_PCS_STAT)) begin
      decode = eee_lpi_pkg::EEE_SEL_STAT;
    end else if (a == byte_addr(`EEE_IDX_CAP)) begin
      decode = eee_lpi_pkg::EEE_SEL_CAP;
    end else if (a == byte_addr(`EEE_IDX_WAKE_CNT)) begin
      decode = eee_lpi_pkg::EEE_SEL_WAKE;
    end else if (a == byte_addr(`EEE_IDX_ADV)) begin
      decode = eee_lpi_pkg::EEE_SEL_ADV;
    end else begin
      decode = eee_lpi_pkg::EEE_SEL_NONE;
    end
  endfunction

  // Byte lanes 0 and 1 carry the 16-bit registers
  function automatic logic [15:0] merge(
    input logic [15:0] old_v,
    input logic [15:0] new_v,
    input logic [1:0]  strb
  );
    merge[7:0]  = strb[0] ? new_v[7:0]  : old_v[7:0];
    merge[15:8] = strb[1] ? new_v[15:8] : old_v[15:8];
  endfunction

  function automatic logic [15:0] read_cfg2(input eee_regs_state_t s);
    read_cfg2 = {1'b0, s.lpi_txer_en, `EEE_CFG2_RSVD_HI_RST, s.pin_sel,
                 `EEE_CFG2_RSVD_LO_RST};
  endfunction

  function automatic logic [15:0] read_cfg3(input eee_regs_state_t s);
    read_cfg3 = {s.cfg3_rsvd, s.bypass, s.np_dis, s.rx_sd, s.cap_en};
  endfunction

  // Reset bit reads one only in the cycle of its pulse
  function automatic logic [15:0] read_ctrl(input eee_regs_state_t s);
    read_ctrl = 16'h0000;
    read_ctrl[`EEE_CTRL_RESET_BIT] = s.pcs_rst;
    read_ctrl[`EEE_CTRL_RXCLK_BIT] = s.rx_clk_stop;
  endfunction

  // Latched LPI bits beside the live PCS and clock levels
  function automatic logic [15:0] read_stat(
    input eee_regs_state_t s,
    input logic            tx_now,
    input logic            rx_now,
    input logic            clk_ok
  );
    read_stat = 16'h0000;
    read_stat[`EEE_STAT_TX_SEEN_BIT] = s.tx_seen;
    read_stat[`EEE_STAT_RX_SEEN_BIT] = s.rx_seen;
    read_stat[`EEE_STAT_TX_NOW_BIT]  = tx_now;
    read_stat[`EEE_STAT_RX_NOW_BIT]  = rx_now;
    read_stat[`EEE_STAT_TXCLK_BIT]   = clk_ok;
  endfunction

  // Capability bits are fixed by build options, never by software
  function automatic logic [15:0] read_cap();
    read_cap = 16'h0000;
    read_cap[`EEE_CAP_100TX_BIT] = CAP_100TX;
    read_cap[`EEE_CAP_1000T_BIT] = CAP_1000T;
  endfunction

  // Only the 100TX advertisement bit is held; the rest read zero
  function automatic logic [15:0] read_adv(input eee_regs_state_t s);
    read_adv = 16'h0000;
    read_adv[`EEE_ADV_100TX_BIT] = s.adv100;
  endfunction

  assign sel    = decode(paddr);
  assign setup  = psel && !penable;
  assign wr_acc = psel && penable && pwrite;
  assign wdata  = merge(16'h0000, pwdata[15:0], pstrb[1:0]);

  // Read side effects happen at the setup edge, with the data capture
  assign cnt_clr = (setup && !pwrite && (sel == eee_lpi_pkg::EEE_SEL_WAKE))
                   || st_q.pcs_rst;

  eee_wake_cnt #(
    .CNT_W (CNT_W)
  ) u_wake_cnt (
    .sys_clk (sys_clk),
    .rst     (rst),
    .inc     (wake_err),
    .clr     (cnt_clr),
    .count_q (wake_cnt)
  );

  always_comb begin
    logic [15:0] old_v;
    logic [15:0] new_v;
    old_v = 16'h0000;
    new_v = 16'h0000;
    st_d = st_q;
    st_d.pcs_rst = 1'b0;

    // Read data is captured at setup and stands through the access
    if (setup) begin
      st_d.err = (sel == eee_lpi_pkg::EEE_SEL_NONE);
      st_d.rdata = 16'h0000;
      if (!pwrite) begin
        case (sel)
          eee_lpi_pkg::EEE_SEL_CFG2: begin
            st_d.rdata = read_cfg2(st_q);
          end
          eee_lpi_pkg::EEE_SEL_CFG3: begin
            st_d.rdata = read_cfg3(st_q);
          end
          eee_lpi_pkg::EEE_SEL_CTRL: begin
            st_d.rdata = read_ctrl(st_q);
          end
          eee_lpi_pkg::EEE_SEL_STAT: begin
            st_d.rdata = read_stat(st_q, tx_lpi_active, rx_lpi_active,
                                   tx_clk_stop_ok);
            // Reading clears the latched bits; a live LPI sets them again
            st_d.tx_seen = 1'b0;
            st_d.rx_seen = 1'b0;
          end
          eee_lpi_pkg::EEE_SEL_CAP: begin
            st_d.rdata = read_cap();
          end
          eee_lpi_pkg::EEE_SEL_WAKE: begin
            st_d.rdata = 16'(wake_cnt);
          end
          eee_lpi_pkg::EEE_SEL_ADV: begin
            st_d.rdata = read_adv(st_q);
          end
          default: begin
            st_d.rdata = 16'h0000;
          end
        endcase
      end
    end

    // Writes land on the completing access edge; read-only bits ignore them
    if (wr_acc) begin
      case (sel)
        eee_lpi_pkg::EEE_SEL_CFG2: begin
          new_v = merge(read_cfg2(st_q), pwdata[15:0], pstrb[1:0]);
          st_d.lpi_txer_en = new_v[`EEE_CFG2_LPI_TXER_BIT];
          st_d.pin_sel = new_v[`EEE_CFG2_SEL_LSB +: 2];
        end
        eee_lpi_pkg::EEE_SEL_CFG3: begin
          old_v = read_cfg3(st_q);
          new_v = merge(old_v, pwdata[15:0], pstrb[1:0]);
          st_d.cfg3_rsvd = new_v[15:4];
          st_d.bypass = new_v[`EEE_CFG3_BYPASS_BIT];
          st_d.np_dis = new_v[`EEE_CFG3_NP_DIS_BIT];
          st_d.rx_sd = new_v[`EEE_CFG3_RX_SD_BIT];
          st_d.cap_en = new_v[`EEE_CFG3_CAP_EN_BIT];
        end
        eee_lpi_pkg::EEE_SEL_CTRL: begin
          if (pstrb[1]) begin
            st_d.pcs_rst = wdata[`EEE_CTRL_RESET_BIT];
            st_d.rx_clk_stop = wdata[`EEE_CTRL_RXCLK_BIT];
          end
        end
        eee_lpi_pkg::EEE_SEL_ADV: begin
          if (pstrb[0]) begin
            st_d.adv100 = wdata[`EEE_ADV_100TX_BIT];
          end
        end
        default: begin
          st_d.err = st_q.err;
        end
      endcase
    end

    // Soft reset of PCS-side registers only; vendor config untouched
    if (st_q.pcs_rst) begin
      st_d.rx_clk_stop = `EEE_RXCLK_RST;
      st_d.adv100 = `EEE_ADV_100TX_RST;
      st_d.tx_seen = 1'b0;
      st_d.rx_seen = 1'b0;
    end

    // Latched LPI events win over any clear in the same cycle
    if (tx_lpi_active) begin
      st_d.tx_seen = 1'b1;
    end
    if (rx_lpi_active) begin
      st_d.rx_seen = 1'b1;
    end

    // Strap sampled once on the first edge after reset release
    if (!st_q.strap_done) begin
      st_d.cap_en = strap_cap_en;
      st_d.strap_done = 1'b1;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      st_q.lpi_txer_en <= 1'b0;
      st_q.pin_sel <= 2'h0;
      st_q.cfg3_rsvd <= `EEE_CFG3_RSVD_RST;
      st_q.bypass <= `EEE_CFG3_BYPASS_RST;
      st_q.np_dis <= `EEE_CFG3_NP_DIS_RST;
      st_q.rx_sd <= `EEE_CFG3_RX_SD_RST;
      st_q.cap_en <= 1'b0;
      st_q.strap_done <= 1'b0;
      st_q.rx_clk_stop <= `EEE_RXCLK_RST;
      st_q.pcs_rst <= 1'b0;
      st_q.adv100 <= `EEE_ADV_100TX_RST;
      st_q.tx_seen <= 1'b0;
      st_q.rx_seen <= 1'b0;
      st_q.rdata <= 16'h0000;
      st_q.err <= 1'b0;
    end else begin
      st_q <= st_d;
    end
  end

  // APB answer: data captured at setup, access completes at once
  assign prdata  = {16'h0000, st_q.rdata};
  assign pready  = psel && penable;
  assign pslverr = psel && penable && st_q.err;

  // TX_ER routing and LPI request qualification
  assign txer_on_irq_pin = (st_q.pin_sel == `EEE_SEL_IRQ_PD);
  assign txer_on_col_pin = (st_q.pin_sel == `EEE_SEL_COL_GPIO);
  assign lpi_req = tx_er && st_q.lpi_txer_en
                   && (txer_on_irq_pin || txer_on_col_pin);

  // Negotiation controls
  assign eee_neg_en = st_q.cap_en;
  assign eee_adv_100tx = st_q.cap_en
                         && (st_q.bypass
                             || (st_q.adv100 && CAP_100TX));
  assign next_page_accept = !st_q.np_dis;
  assign rx_path_pd = st_q.rx_sd && lpi_quiet;
  assign rx_clk_stop_ok = st_q.rx_clk_stop;
  assign pcs_soft_reset = st_q.pcs_rst;

endmodule // eee_lpi_regs

// ---- test/eee_lpi_regs_props.sv ----
// Port-level assertion checker for the EEE LPI register bank
module eee_lpi_regs_props (
  input wire logic        sys_clk,
  input wire logic        rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        tx_er,
  input wire logic        lpi_quiet,
  input wire logic        lpi_req,
  input wire logic        txer_on_irq_pin,
  input wire logic        txer_on_col_pin,
  input wire logic        eee_adv_100tx,
  input wire logic        eee_neg_en,
  input wire logic        next_page_accept,
  input wire logic        rx_path_pd,
  input wire logic        rx_clk_stop_ok,
  input wire logic        pcs_soft_reset
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  AST_READY: assert property (psel && penable |-> pready)
    else $error("access cycle without ready");
  AST_LPI_OFF: assert property (!tx_er |-> !lpi_req)
    else $error("lpi request without tx_er");
  AST_LPI_PIN: assert property (
    lpi_req |-> txer_on_irq_pin || txer_on_col_pin)
    else $error("lpi request with no pin selected");
  AST_PIN_ONE: assert property (
    !(txer_on_irq_pin && txer_on_col_pin))
    else $error("two tx_er pins selected");
  AST_RX_PD: assert property (rx_path_pd |-> lpi_quiet)
    else $error("rx path down outside quiet");
  AST_NEG_ADV: assert property (eee_adv_100tx |-> eee_neg_en)
    else $error("advertised while capability off");
  AST_SRST_ONE: assert property (
    pcs_soft_reset |=> !pcs_soft_reset)
    else $error("soft reset longer than a cycle");
  AST_SRST_SRC: assert property (
    $rose(pcs_soft_reset) |-> $past(pwrite) && $past(pwdata[15]))
    else $error("soft reset without a write");
  AST_SRST_CLR: assert property (
    pcs_soft_reset |=> !rx_clk_stop_ok)
    else $error("soft reset kept rx clock bit");
  AST_SRST_KEEP: assert property (
    pcs_soft_reset |=> $stable(next_page_accept))
    else $error("soft reset touched config");
  AST_RD_HI: assert property (
    pready && !pwrite |-> prdata[31:16] == 16'h0000)
    else $error("upper read bits not zero");
  COV_SRST: cover property (pcs_soft_reset);
  COV_ERR: cover property (pslverr);
  COV_LPI: cover property (lpi_req);
endmodule // eee_lpi_regs_props

bind eee_lpi_regs eee_lpi_regs_props props_u (
  .sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .tx_er(tx_er), .lpi_quiet(lpi_quiet),
  .lpi_req(lpi_req), .txer_on_irq_pin(txer_on_irq_pin),
  .txer_on_col_pin(txer_on_col_pin), .eee_adv_100tx(eee_adv_100tx),
  .eee_neg_en(eee_neg_en), .next_page_accept(next_page_accept),
  .rx_path_pd(rx_path_pd), .rx_clk_stop_ok(rx_clk_stop_ok),
  .pcs_soft_reset(pcs_soft_reset));

// ---- test/eee_mac_model.sv ----
// MAC and PCS side stand-in driving the LPI levels and wake faults
module eee_mac_model (
  input  wire logic sys_clk,
  output logic      tx_er,
  output logic      tx_lpi_active,
  output logic      rx_lpi_active,
  output logic      lpi_quiet,
  output logic      tx_clk_stop_ok,
  output logic      wake_err
);
  timeunit 1ns;
  timeprecision 1ps;
  logic tx_clk_halted;
  // Transmit clock held only in LPI and only when the PHY permits it
  assign tx_clk_halted = tx_lpi_active & tx_clk_stop_ok;
  initial begin
    {tx_er, tx_lpi_active, rx_lpi_active, lpi_quiet, tx_clk_stop_ok} = '0;
    wake_err = 1'b0;
  end
  task automatic drive(input logic [4:0] v);
    @(posedge sys_clk);
    {tx_er, tx_lpi_active, rx_lpi_active, lpi_quiet, tx_clk_stop_ok} <= v;
  endtask
  // Back-to-back failed wakes, one per cycle
  task automatic wake(input int n);
    @(posedge sys_clk);
    wake_err <= 1'b1;
    repeat (n) @(posedge sys_clk);
    wake_err <= 1'b0;
  endtask
endmodule // eee_mac_model

// ---- test/eee_lpi_config_status_tb.sv ----
// Self-checking bench for the EEE LPI register bank
`include "eee_lpi_params.svh"
module eee_lpi_config_status_tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic        wr;
    logic [16:0] a;
    logic [15:0] d;
    logic [15:0] e;
  } eee_row_t;
  localparam logic [16:0] A_CFG2 = 17'h01340;
  localparam logic [16:0] A_CFG3 = 17'h01344;
  localparam logic [16:0] A_CTRL = 17'h0C000;
  localparam logic [16:0] A_STAT = 17'h0C004;
  localparam logic [16:0] A_CAP  = 17'h0C050;
  localparam logic [16:0] A_WAKE = 17'h0C058;
  localparam logic [16:0] A_ADV  = 17'h1C0F0;
  localparam logic [15:0] CFG2_RST = {2'b00, `EEE_CFG2_RSVD_HI_RST,
    2'b00, `EEE_CFG2_RSVD_LO_RST};
  localparam logic [15:0] CFG3_RST = {`EEE_CFG3_RSVD_RST,
    `EEE_CFG3_BYPASS_RST, `EEE_CFG3_NP_DIS_RST, `EEE_CFG3_RX_SD_RST, 1'b1};
  localparam eee_row_t ROWS [15] = '{
    '{1'b0, A_CFG2, 16'h0000, CFG2_RST}, '{1'b0, A_CFG3, 16'h0000, CFG3_RST},
    '{1'b0, A_CTRL, 16'h0000, 16'h0000}, '{1'b0, A_STAT, 16'h0000, 16'h0000},
    '{1'b0, A_CAP, 16'h0000, 16'h0000}, '{1'b0, A_WAKE, 16'h0000, 16'h0000},
    '{1'b0, A_ADV, 16'h0000, 16'h0002},
    '{1'b1, A_CFG2, 16'hFFFF, CFG2_RST | 16'h4060},
    '{1'b1, A_CFG3, 16'h1234, 16'h1234}, '{1'b1, A_CTRL, 16'h7FFF, 16'h0400},
    '{1'b1, A_STAT, 16'hFFFF, 16'h0000}, '{1'b1, A_CAP, 16'hFFFF, 16'h0000},
    '{1'b1, A_WAKE, 16'hFFFF, 16'h0000}, '{1'b1, A_ADV, 16'hFFFF, 16'h0002},
    '{1'b1, A_ADV, 16'h0000, 16'h0000}};
  logic        sys_clk, rst, psel, penable, pwrite, strap_cap_en, er;
  logic [16:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  pstrb, strb;
  logic        pready, pslverr, tx_er, tx_lpi_active, rx_lpi_active;
  logic        lpi_quiet, tx_clk_stop_ok, wake_err, lpi_req, txer_on_irq_pin;
  logic        txer_on_col_pin, eee_adv_100tx, eee_neg_en, next_page_accept;
  logic        rx_path_pd, rx_clk_stop_ok, pcs_soft_reset;
  int          err_count, n_tests;

  eee_lpi_regs #(.ADDR_W(17)) dut_u (.sys_clk(sys_clk), .rst(rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .strap_cap_en(strap_cap_en), .tx_er(tx_er),
    .tx_lpi_active(tx_lpi_active), .rx_lpi_active(rx_lpi_active),
    .lpi_quiet(lpi_quiet), .tx_clk_stop_ok(tx_clk_stop_ok),
    .wake_err(wake_err), .lpi_req(lpi_req),
    .txer_on_irq_pin(txer_on_irq_pin), .txer_on_col_pin(txer_on_col_pin),
    .eee_adv_100tx(eee_adv_100tx), .eee_neg_en(eee_neg_en),
    .next_page_accept(next_page_accept), .rx_path_pd(rx_path_pd),
    .rx_clk_stop_ok(rx_clk_stop_ok), .pcs_soft_reset(pcs_soft_reset));
  eee_mac_model mac_u (.sys_clk(sys_clk), .tx_er(tx_er),
    .tx_lpi_active(tx_lpi_active), .rx_lpi_active(rx_lpi_active),
    .lpi_quiet(lpi_quiet), .tx_clk_stop_ok(tx_clk_stop_ok),
    .wake_err(wake_err));

  initial sys_clk = 1'b0;
  always #4 sys_clk = ~sys_clk;

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      err_count++;
      $display("mismatch t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic apb(input logic w, input logic [16:0] a,
                     input logic [15:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {16'h0000, d};
    pstrb <= strb;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wrap_up();
    if (err_count == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    {rst, strap_cap_en} = 2'b11;
    {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
    strb = 4'h3;
    repeat (8) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (2) @(posedge sys_clk);
    foreach (ROWS[i]) begin
      if (ROWS[i].wr) apb(1'b1, ROWS[i].a, ROWS[i].d);
      apb(1'b0, ROWS[i].a, 16'h0000);
      chk(rd, {16'h0000, ROWS[i].e});
    end
    @(negedge sys_clk);
    chk(rx_clk_stop_ok, 1'b1);
    apb(1'b1, 17'h00100, 16'hFFFF);
    chk(er, 1'b1);
    apb(1'b0, 17'h00100, 16'h0000);
    chk({rd[31:1], er}, 32'h1);
    mac_u.drive(5'b10000);
    for (int i = 0; i < 8; i++) begin
      apb(1'b1, A_CFG2, {1'b0, i[2], 7'h00, i[1:0], 5'h00});
      @(negedge sys_clk);
      chk(lpi_req, i[2] && (i[1:0] == 1 || i[1:0] == 2));
      chk(txer_on_irq_pin, i[1:0] == 1);
      chk(txer_on_col_pin, i[1:0] == 2);
    end
    mac_u.drive(5'b00010);
    for (int i = 0; i < 16; i++) begin
      apb(1'b1, A_CFG3, {12'h018, i[3:0]});
      @(negedge sys_clk);
      chk(eee_neg_en, i[0]);
      chk(eee_adv_100tx, i[0] & i[3]);
      chk({next_page_accept, rx_path_pd}, {!i[2], i[1]});
    end
    mac_u.drive(5'b01101);
    @(negedge sys_clk);
    chk(rx_path_pd, 1'b0);
    apb(1'b0, A_STAT, 16'h0000);
    chk(rd, 32'h0F40);
    mac_u.drive(5'b00000);
    apb(1'b0, A_STAT, 16'h0000);
    chk(rd, 32'h0C00);
    apb(1'b0, A_STAT, 16'h0000);
    chk(rd, 32'h0000);
    mac_u.wake(3);
    apb(1'b0, A_WAKE, 16'h0000);
    chk(rd, 32'h0003);
    apb(1'b0, A_WAKE, 16'h0000);
    chk(rd, 32'h0000);
    mac_u.wake(65537);
    apb(1'b0, A_WAKE, 16'h0000);
    chk(rd, 32'hFFFF);
    mac_u.wake(2);
    apb(1'b1, A_CTRL, 16'h8400);
    @(negedge sys_clk);
    chk(pcs_soft_reset, 1'b1);
    apb(1'b0, A_CTRL, 16'h0000);
    chk(rd, 32'h0000);
    chk(rx_clk_stop_ok, 1'b0);
    apb(1'b0, A_ADV, 16'h0000);
    chk(rd, 32'h0002);
    apb(1'b0, A_WAKE, 16'h0000);
    chk(rd, 32'h0000);
    apb(1'b0, A_CFG3, 16'h0000);
    chk(rd, 32'h018F);
    // Second reset with the strap low
    strap_cap_en <= 1'b0;
    rst <= 1'b1;
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (2) @(posedge sys_clk);
    @(negedge sys_clk);
    chk(eee_neg_en, 1'b0);
    chk(pcs_soft_reset, 1'b0);
    apb(1'b0, A_CFG3, 16'h0000);
    chk(rd, {16'h0000, CFG3_RST & 16'hFFFE});
    // Single byte lanes
    strb <= 4'h1;
    apb(1'b1, A_CFG3, 16'hFFF0);
    apb(1'b1, A_CTRL, 16'h8400);
    @(negedge sys_clk);
    chk(pcs_soft_reset, 1'b0);
    chk(rx_clk_stop_ok, 1'b0);
    apb(1'b0, A_CFG3, 16'h0000);
    chk(rd, {16'h0000, CFG3_RST[15:8], 8'hF0});
    strb <= 4'h2;
    apb(1'b1, A_CFG3, 16'h2200);
    apb(1'b1, A_ADV, 16'h0000);
    apb(1'b0, A_CFG3, 16'h0000);
    chk(rd, 32'h22F0);
    apb(1'b0, A_ADV, 16'h0000);
    chk(rd, 32'h0002);
    wrap_up();
  end

  initial begin
    #800000;
    err_count++;
    wrap_up();
  end
endmodule // eee_lpi_config_status_tb
